/* File: tb/slctm_checker.sv */
// assertion checker for the loop config and test pin block
`timescale 1ns/10ps
module slctm_checker
	import slctm_pkg::*;
(
	// clock, reset and bus
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	// decoded settings
	input wire logic [RES_W-1:0] o_loop_res_a_sel,
	input wire logic [OHM_W-1:0] o_loop_res_a_ohm,
	input wire logic [RES_W-1:0] o_loop_res_b_sel,
	input wire logic o_loop_res_reserved,
	input wire logic [CAP_W-1:0] o_loop_cap_a_sel,
	input wire logic [5:0] o_loop_cap_a_pf,
	input wire logic [CAP_W-1:0] o_loop_cap_b_sel,
	input wire logic [7:0] o_loop_cap_b_pf,
	input wire logic [PUMP_W-1:0] o_pump_current_code,
	input wire logic [UA_W-1:0] o_pump_current_ua,
	input wire logic o_div_en,
	input wire logic o_pll_en,
	input wire logic o_vco_en,
	input wire logic o_power_down,
	input wire logic o_lock_test_pin_oe
);
	// outputs hold reset zeros until the first edge after release
	logic [1:0] live;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			live <= 2'b00;
		end else begin
			live <= {live[0], 1'b1};
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
	ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
	enable_order_a: assert property (live[1] && !o_power_down |-> o_div_en && (o_pll_en || !o_vco_en))
		else $error("bad enable set");
	power_down_a: assert property (o_power_down |-> !o_div_en && !o_pll_en && !o_vco_en && !o_lock_test_pin_oe)
		else $error("power down leaves blocks on");
	pump_scale_a: assert property (live[1] |-> o_pump_current_ua == (12'(o_pump_current_code) + 12'h001) * 12'h064)
		else $error("pump current scale");
	res_reserved_a: assert property (live[1] |->
		o_loop_res_reserved == (o_loop_res_a_sel > 3'h4 || o_loop_res_b_sel > 3'h4)) else $error("reserved flag");
	res_zero_a: assert property (o_loop_res_a_sel > 3'h4 |-> o_loop_res_a_ohm == '0) else $error("reserved ohms");
	// power-down keeps the programmed caps but drops the enables
	cap_a_scale_a: assert property (o_loop_cap_a_pf != '0 |-> (o_vco_en || o_power_down) &&
		o_loop_cap_a_pf == 6'(o_loop_cap_a_sel[3:1]) * 6'h05 + 6'(o_loop_cap_a_sel[0])) else $error("cap a value");
	cap_b_scale_a: assert property (o_loop_cap_b_pf != '0 |-> (o_vco_en || o_power_down) &&
		o_loop_cap_b_pf == 8'(o_loop_cap_b_sel[3]) * 8'h64 + 8'(o_loop_cap_b_sel[2:1]) * 8'h14 +
		8'(o_loop_cap_b_sel[0]) * 8'h05) else $error("cap b value");
	commit_only_a: assert property ($changed(o_loop_cap_a_sel) |-> $past(o_wb_ack) || $past(o_wb_ack, 2)
		|| $past(o_wb_ack, 3)) else $error("change without commit");
	commit_c: cover property (o_wb_ack ##1 $changed(o_loop_cap_a_sel));
	power_c: cover property (o_power_down);
	reserved_c: cover property (o_loop_res_reserved);
endmodule : slctm_checker

bind slctm_top slctm_checker slctm_checker_inst (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_loop_res_a_sel,
	.o_loop_res_a_ohm, .o_loop_res_b_sel, .o_loop_res_reserved, .o_loop_cap_a_sel, .o_loop_cap_a_pf, .o_loop_cap_b_sel,
	.o_loop_cap_b_pf, .o_pump_current_code, .o_pump_current_ua, .o_div_en, .o_pll_en, .o_vco_en, .o_power_down,
	.o_lock_test_pin_oe);

/* File: tb/test_synth_loop_config_and_test_mux.sv */
// self-checking bench for the loop config and test pin block
`timescale 1ns/10ps
module test_synth_loop_config_and_test_mux;
	import slctm_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fl = 1'b0, dl = 1'b0, al = 1'b0, ack;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic [5:0] dg = 6'h00, cpa;
	logic [RES_W-1:0] ra, rb;
	logic [OHM_W-1:0] ohma, ohmb;
	logic [CAP_W-1:0] ca, cb;
	logic [7:0] cpb;
	logic [PUMP_W-1:0] pc;
	logic [UA_W-1:0] pua;
	logic rres, den, pen, ven, pd, xo, pin, oe;
	logic [15:0] sl = 16'h0, sc = 16'h0, sf = 16'h0, aloop = 16'h0, actl = 16'h0, afst = 16'h0;
	int failures = 0, checks = 0, seed = 32'h6d2780e8;
	logic [31:0] d;
	logic xpin;
	logic [UA_W-1:0] xua;

	slctm_top slctm_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_fastlock(fl),
		.i_dig_lock(dl), .i_ana_lock(al), .i_ndiv_pulse(dg[0]), .i_ndiv_half(dg[1]), .i_rdiv_pulse(dg[2]),
		.i_rdiv_half(dg[3]), .i_pd_up(dg[4]), .i_pd_down(dg[5]), .o_loop_res_a_sel(ra), .o_loop_res_a_ohm(ohma),
		.o_loop_res_b_sel(rb), .o_loop_res_b_ohm(ohmb), .o_loop_res_reserved(rres), .o_loop_cap_a_sel(ca),
		.o_loop_cap_a_pf(cpa), .o_loop_cap_b_sel(cb), .o_loop_cap_b_pf(cpb), .o_pump_current_code(pc),
		.o_pump_current_ua(pua), .o_div_en(den), .o_pll_en(pen), .o_vco_en(ven), .o_power_down(pd),
		.o_crystal_osc_sel(xo), .o_lock_test_pin(pin), .o_lock_test_pin_oe(oe));

	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function automatic logic [OHM_W-1:0] ohm(input logic [2:0] c);
		case (c)
			3'h0: return OHM_LOW;
			3'h1: return OHM_1K;
			3'h2: return OHM_2K;
			3'h3: return OHM_4K;
			3'h4: return OHM_16K;
			default: return '0;
		endcase
	endfunction : ohm

	function automatic logic [1:0] pinexp(input logic [3:0] s);
		case (s)
			4'h0, 4'he, 4'hf: return 2'b00;
			4'h1: return 2'b11;
			4'h2: return 2'b10;
			4'h3: return {1'b1, dl};
			4'h4: return {1'b1, ~dl};
			4'h5: return {~dl, 1'b0};
			4'h6: return {~al, 1'b0};
			4'h7: return {1'b1, al};
			default: return {1'b1, dg[s-4'h8]};
		endcase
	endfunction : pinexp

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] w, input logic [3:0] s);
		return {s[1] ? w[15:8] : o[15:8], s[0] ? w[7:0] : o[7:0]};
	endfunction : merge

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] v);
		int n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= v;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		if (n == 20) failures++;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] v);
		wb(1'b1, a, s, v);
		case (a)
			REG_LOOP: sl = merge(sl, v, s);
			REG_CTRL: sc = merge(sc, v, s);
			REG_FAST: sf = merge(sf, v, s);
			REG_COMMIT: if (s[0] && v[0]) begin
				aloop = sl;
				actl = sc;
				afst = sf;
			end
			default: ;
		endcase
	endtask : wr

	task automatic verify();
		logic [2:0] xa, xb;
		logic [4:0] xp;
		logic on, full;
		logic [1:0] po;
		xa = fl ? afst[2:0] : aloop[2:0];
		xb = fl ? afst[6:4] : aloop[6:4];
		xp = fl ? afst[12:8] : actl[8:4];
		on = ~actl[2];
		full = actl[1:0] == 2'b00;
		po = on ? pinexp(actl[15:12]) : 2'b00;
		chk(pd, actl[2], "pd");
		chk(xo, actl[3], "xo");
		chk(oe, po[1], "oe");
		chk(pin, po[0], "pin");
		chk({den, pen, ven}, !on ? 3'b000 : actl[1:0] == 2'b01 ? 3'b110 :
			actl[1:0] == 2'b10 ? 3'b100 : 3'b111, "en");
		chk({ra, rb, pc, ca, cb}, {xa, xb, xp, aloop[11:8], aloop[15:12]}, "codes");
		if (on) begin
			chk(pua, (12'(xp) + 12'h001) * PUMP_STEP_UA, "ua");
			chk({ohma, ohmb}, full ? {ohm(xa), ohm(xb)} : 30'h0, "ohm");
			chk(rres, xa > 3'h4 || xb > 3'h4, "rsv");
			chk(cpa, full ? 6'(aloop[11:9]) * 6'h05 + 6'(aloop[8]) : 6'h00, "cap a");
			chk(cpb, full ? 8'(aloop[15]) * 8'h64 + 8'(aloop[14:13]) * 8'h14 + 8'(aloop[12]) * 8'h05 : 8'h00, "cap b");
		end
		xpin = po[0];
		xua = (12'(xp) + 12'h001) * PUMP_STEP_UA;
	endtask : verify

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		verify();
		wb(1'b0, 8'h20, 4'hf, 32'h0);
		chk(rd, 32'h0, "unmapped");
		for (int i = 0; i < 64; i++) begin
			{fl, dl, al, dg} <= 9'($random(seed));
			wr(REG_LOOP, 4'($random(seed)), $random(seed));
			wr(REG_FAST, 4'($random(seed)), $random(seed));
			d = $random(seed);
			d[15:12] = 4'(i);
			d[1:0] = 2'(i >> 4);
			d[2] = i % 7 == 6;
			wr(REG_CTRL, 4'h3, d);
			wr(REG_COMMIT, 4'he, 32'h1);
			verify();
			wb(1'b0, REG_STATUS, 4'hf, 32'h0);
			chk(rd[ST_PEND_BIT], (sl != aloop) || (sc != actl) || (sf != afst), "pending");
			wr(REG_COMMIT, 4'h1, 32'h1);
			@(posedge clk);
			verify();
			wb(1'b0, REG_LOOP, 4'hf, 32'h0);
			chk(rd, {16'h0, sl}, "loop");
			wb(1'b0, REG_STATUS, 4'hf, 32'h0);
			chk(rd, {4'h0, xua, 11'h000, xpin, 1'b0, al, dl, fl}, "status");
			fl <= ~fl;
			repeat (2) @(posedge clk);
			verify();
		end
		conclude();
	end

	initial begin
		#(25 * 20000);
		failures++;
		conclude();
	end
endmodule : test_synth_loop_config_and_test_mux

/* File: verilog/slctm_pkg.sv */
// constants, field layout and types of the synthesizer loop config and test mux block
//
// What this block does
// - Resistor A code 0..4 gives 200 ohm, 1k, 2k, 4k, 16k; 5-7 reserved; full mode, no fastlock.
// - Resistor B uses the same encoding as A, same full mode and fastlock conditions.
// - Capacitor A code 0..15 maps 0,1,5,6,...36 pF, applied in full mode.
// - Capacitor B code 0..15 maps 0,5,20,25,...165 pF, applied in full mode.
// - Mode 0 all on, 1 VCO off, 2 divider only, 3 test all on.
// - Power-down stops the device but keeps every programmed field.
// - Crystal mode bit turns the reference input pair into a crystal oscillator.
// - Pump current equals (code plus one) times 100 uA, 100 uA to 3.2 mA.
// - Test pin code 0 high impedance, 1 drives high, 2 drives low; 14-15 reserved.
// - Codes 3,4,5 digital lock push-pull, inverted, open drain; 6,7 analog lock.
// - Codes 8-13 route N, N/2, R, R/2, phase up, phase down to the pin.
// - While fastlock is engaged, fast pump code and fast resistor codes replace normal ones.
package slctm_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_LOOP = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_FAST = 8'h08;
	localparam logic [7:0] REG_COMMIT = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// ----------------------------------------------------------------
	// field positions and widths
	// ----------------------------------------------------------------
	localparam int RES_W = 3;
	localparam int CAP_W = 4;
	localparam int PUMP_W = 5;
	localparam int SEL_W = 4;
	localparam int OHM_W = 15;
	localparam int UA_W = 12;
	localparam int LOOP_RES_A_LSB = 0;
	localparam int LOOP_RES_B_LSB = 4;
	localparam int LOOP_CAP_A_LSB = 8;
	localparam int LOOP_CAP_B_LSB = 12;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PD_BIT = 2;
	localparam int CTRL_XO_BIT = 3;
	localparam int CTRL_PUMP_LSB = 4;
	localparam int CTRL_SEL_LSB = 12;
	localparam int FAST_RES_A_LSB = 0;
	localparam int FAST_RES_B_LSB = 4;
	localparam int FAST_PUMP_LSB = 8;
	localparam int COMMIT_BIT = 0;
	localparam int ST_FAST_BIT = 0;
	localparam int ST_DLOCK_BIT = 1;
	localparam int ST_ALOCK_BIT = 2;
	localparam int ST_PEND_BIT = 3;
	localparam int ST_PIN_BIT = 4;
	localparam int ST_UA_LSB = 16;

	// ----------------------------------------------------------------
	// reset values and analog figures
	// ----------------------------------------------------------------
	localparam logic [15:0] LOOP_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] FAST_RST = 16'h0000;
	localparam logic [OHM_W-1:0] OHM_LOW = 15'h00c8;
	localparam logic [OHM_W-1:0] OHM_1K = 15'h03e8;
	localparam logic [OHM_W-1:0] OHM_2K = 15'h07d0;
	localparam logic [OHM_W-1:0] OHM_4K = 15'h0fa0;
	localparam logic [OHM_W-1:0] OHM_16K = 15'h3e80;
	localparam logic [UA_W-1:0] PUMP_STEP_UA = 12'h064;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SLCTM_MODE_FULL = 2'b00,
		SLCTM_MODE_EXT_VCO = 2'b01,
		SLCTM_MODE_DIV_ONLY = 2'b10,
		SLCTM_MODE_TEST = 2'b11
	} slctm_mode_t;

	typedef enum logic [3:0] {
		SLCTM_PIN_HIZ = 4'b0000,
		SLCTM_PIN_HIGH = 4'b0001,
		SLCTM_PIN_LOW = 4'b0010,
		SLCTM_PIN_DLOCK_PP = 4'b0011,
		SLCTM_PIN_DLOCK_INV = 4'b0100,
		SLCTM_PIN_DLOCK_OD = 4'b0101,
		SLCTM_PIN_ALOCK_OD = 4'b0110,
		SLCTM_PIN_ALOCK_PP = 4'b0111,
		SLCTM_PIN_NDIV = 4'b1000,
		SLCTM_PIN_NDIV_HALF = 4'b1001,
		SLCTM_PIN_RDIV = 4'b1010,
		SLCTM_PIN_RDIV_HALF = 4'b1011,
		SLCTM_PIN_PD_UP = 4'b1100,
		SLCTM_PIN_PD_DOWN = 4'b1101,
		SLCTM_PIN_RSV14 = 4'b1110,
		SLCTM_PIN_RSV15 = 4'b1111
	} slctm_pin_t;

endpackage : slctm_pkg

/* File: verilog/slctm_res_dec.sv */
// loop filter resistor selector: normal or fastlock code, decoded to ohms
`timescale 1ns/10ps
module slctm_res_dec
	import slctm_pkg::*;
(
	// selector codes
	input wire logic [RES_W-1:0] i_norm_sel,
	input wire logic [RES_W-1:0] i_fast_sel,
	// conditions
	input wire logic i_fastlock,
	input wire logic i_full_mode,
	// decoded result
	output logic [RES_W-1:0] o_sel,
	output logic [OHM_W-1:0] o_ohm,
	output logic o_reserved
);

	always_comb begin
		o_sel = i_fastlock ? i_fast_sel : i_norm_sel;
		o_reserved = 1'b0;
		unique case (o_sel)
			3'h0: o_ohm = OHM_LOW;
			3'h1: o_ohm = OHM_1K;
			3'h2: o_ohm = OHM_2K;
			3'h3: o_ohm = OHM_4K;
			3'h4: o_ohm = OHM_16K;
			default: begin
				o_ohm = '0;
				o_reserved = 1'b1;
			end
		endcase
		// outside full mode the internal resistor is not in circuit
		if (!i_full_mode) begin
			o_ohm = '0;
		end
	end

endmodule : slctm_res_dec

/* File: verilog/slctm_top.sv */
// Wishbone register bank, staged commit, config decode and lock/test pin mux
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
module slctm_top
	import slctm_pkg::*;
#(
	parameter int AW = 8
)(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// wishbone classic slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [AW-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// device state inputs
	input wire logic i_fastlock,
	input wire logic i_dig_lock,
	input wire logic i_ana_lock,
	// diagnostic sources
	input wire logic i_ndiv_pulse,
	input wire logic i_ndiv_half,
	input wire logic i_rdiv_pulse,
	input wire logic i_rdiv_half,
	input wire logic i_pd_up,
	input wire logic i_pd_down,
	// loop filter settings
	output logic [RES_W-1:0] o_loop_res_a_sel,
	output logic [OHM_W-1:0] o_loop_res_a_ohm,
	output logic [RES_W-1:0] o_loop_res_b_sel,
	output logic [OHM_W-1:0] o_loop_res_b_ohm,
	output logic o_loop_res_reserved,
	output logic [CAP_W-1:0] o_loop_cap_a_sel,
	output logic [5:0] o_loop_cap_a_pf,
	output logic [CAP_W-1:0] o_loop_cap_b_sel,
	output logic [7:0] o_loop_cap_b_pf,
	// charge pump
	output logic [PUMP_W-1:0] o_pump_current_code,
	output logic [UA_W-1:0] o_pump_current_ua,
	// block enables and oscillator
	output logic o_div_en,
	output logic o_pll_en,
	output logic o_vco_en,
	output logic o_power_down,
	output logic o_crystal_osc_sel,
	// lock_test_pin value and drive enable
	output logic o_lock_test_pin,
	output logic o_lock_test_pin_oe
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	generate
		if (AW < 5) begin : g_aw_check
			$error("slctm_top: AW must be at least 5");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [15:0] stg_loop;
		logic [15:0] stg_ctrl;
		logic [15:0] stg_fast;
		logic [15:0] act_loop;
		logic [15:0] act_ctrl;
		logic [15:0] act_fast;
		logic [RES_W-1:0] res_a_sel;
		logic [OHM_W-1:0] res_a_ohm;
		logic [RES_W-1:0] res_b_sel;
		logic [OHM_W-1:0] res_b_ohm;
		logic res_rsv;
		logic [CAP_W-1:0] cap_a_sel;
		logic [5:0] cap_a_pf;
		logic [CAP_W-1:0] cap_b_sel;
		logic [7:0] cap_b_pf;
		logic [PUMP_W-1:0] pump_code;
		logic [UA_W-1:0] pump_ua;
		logic div_en;
		logic pll_en;
		logic vco_en;
		logic pd;
		logic xo;
		logic pin;
		logic pin_oe;
	} slctm_state_t;

	slctm_state_t st;
	slctm_state_t next_st;

	// ----------------------------------------------------------------
	// active field views
	// ----------------------------------------------------------------
	logic [RES_W-1:0] res_a_norm;
	logic [RES_W-1:0] res_b_norm;
	logic [RES_W-1:0] res_a_fast;
	logic [RES_W-1:0] res_b_fast;
	logic [CAP_W-1:0] cap_a;
	logic [CAP_W-1:0] cap_b;
	logic [PUMP_W-1:0] pump_norm;
	logic [PUMP_W-1:0] pump_fast;
	slctm_mode_t mode;
	slctm_pin_t pin_sel;
	logic act_pd;
	logic act_xo;
	logic full_mode;
	logic [RES_W-1:0] res_a_sel;
	logic [OHM_W-1:0] res_a_ohm;
	logic res_a_rsv;
	logic [RES_W-1:0] res_b_sel;
	logic [OHM_W-1:0] res_b_ohm;
	logic res_b_rsv;

	assign res_a_norm = st.act_loop[LOOP_RES_A_LSB +: RES_W];
	assign res_b_norm = st.act_loop[LOOP_RES_B_LSB +: RES_W];
	assign cap_a = st.act_loop[LOOP_CAP_A_LSB +: CAP_W];
	assign cap_b = st.act_loop[LOOP_CAP_B_LSB +: CAP_W];
	assign res_a_fast = st.act_fast[FAST_RES_A_LSB +: RES_W];
	assign res_b_fast = st.act_fast[FAST_RES_B_LSB +: RES_W];
	assign pump_fast = st.act_fast[FAST_PUMP_LSB +: PUMP_W];
	assign pump_norm = st.act_ctrl[CTRL_PUMP_LSB +: PUMP_W];
	assign mode = slctm_mode_t'(st.act_ctrl[CTRL_MODE_LSB +: 2]);
	assign pin_sel = slctm_pin_t'(st.act_ctrl[CTRL_SEL_LSB +: SEL_W]);
	assign act_pd = st.act_ctrl[CTRL_PD_BIT];
	assign act_xo = st.act_ctrl[CTRL_XO_BIT];
	assign full_mode = (mode == SLCTM_MODE_FULL);

	// ----------------------------------------------------------------
	// resistor selectors
	// ----------------------------------------------------------------
	slctm_res_dec u_res_a (
		.i_norm_sel(res_a_norm),
		.i_fast_sel(res_a_fast),
		.i_fastlock(i_fastlock),
		.i_full_mode(full_mode),
		.o_sel(res_a_sel),
		.o_ohm(res_a_ohm),
		.o_reserved(res_a_rsv)
	);

	slctm_res_dec u_res_b (
		.i_norm_sel(res_b_norm),
		.i_fast_sel(res_b_fast),
		.i_fastlock(i_fastlock),
		.i_full_mode(full_mode),
		.o_sel(res_b_sel),
		.o_ohm(res_b_ohm),
		.o_reserved(res_b_rsv)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_val,
		input logic [31:0] wdat,
		input logic [3:0] sel
	);
		logic [15:0] res;
		res = old_val;
		if (sel[0]) begin
			res[7:0] = wdat[7:0];
		end
		if (sel[1]) begin
			res[15:8] = wdat[15:8];
		end
		return res;
	endfunction : lane_merge

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic req;
	logic [7:0] adr;
	logic pending;
	logic [PUMP_W-1:0] pump_eff;

	assign adr = 8'(i_wb_adr);
	assign req = i_wb_cyc && i_wb_stb && !st.ack;
	assign pending = (st.stg_loop != st.act_loop) ||
		(st.stg_ctrl != st.act_ctrl) || (st.stg_fast != st.act_fast);

	always_comb begin
		next_st = st;
		// one wait state, ack drops the cycle after it was given
		next_st.ack = req;
		next_st.rdat = '0;

		// register access, effective at the ack edge
		if (req && i_wb_we) begin
			unique case (adr)
				REG_LOOP: next_st.stg_loop = lane_merge(st.stg_loop, i_wb_dat, i_wb_sel);
				REG_CTRL: next_st.stg_ctrl = lane_merge(st.stg_ctrl, i_wb_dat, i_wb_sel);
				REG_FAST: next_st.stg_fast = lane_merge(st.stg_fast, i_wb_dat, i_wb_sel);
				REG_COMMIT: begin
					// all three words move at once, so no output sees half a setting
					if (i_wb_sel[0] && i_wb_dat[COMMIT_BIT]) begin
						next_st.act_loop = st.stg_loop;
						next_st.act_ctrl = st.stg_ctrl;
						next_st.act_fast = st.stg_fast;
					end
				end
				default: ;
			endcase
		end else if (req) begin
			unique case (adr)
				REG_LOOP: next_st.rdat = {16'h0000, st.stg_loop};
				REG_CTRL: next_st.rdat = {16'h0000, st.stg_ctrl};
				REG_FAST: next_st.rdat = {16'h0000, st.stg_fast};
				REG_STATUS: begin
					next_st.rdat[ST_FAST_BIT] = i_fastlock;
					next_st.rdat[ST_DLOCK_BIT] = i_dig_lock;
					next_st.rdat[ST_ALOCK_BIT] = i_ana_lock;
					next_st.rdat[ST_PEND_BIT] = pending;
					next_st.rdat[ST_PIN_BIT] = st.pin;
					next_st.rdat[ST_UA_LSB +: UA_W] = st.pump_ua;
				end
				default: ;
			endcase
		end

		// loop filter decode
		next_st.res_a_sel = res_a_sel;
		next_st.res_a_ohm = res_a_ohm;
		next_st.res_b_sel = res_b_sel;
		next_st.res_b_ohm = res_b_ohm;
		next_st.res_rsv = res_a_rsv || res_b_rsv;
		next_st.cap_a_sel = cap_a;
		next_st.cap_b_sel = cap_b;
		next_st.cap_a_pf = '0;
		next_st.cap_b_pf = '0;
		if (full_mode) begin
			// 1 pF on bit 0, 5 pF per step on bits 3:1
			next_st.cap_a_pf = 6'(cap_a[0]) + 6'(cap_a[3:1]) * 6'h05;
			// 5 pF bit 0, 20 pF per step on bits 2:1, 100 pF bit 3
			next_st.cap_b_pf = (cap_b[0] ? 8'h05 : 8'h00) + 8'(cap_b[2:1]) * 8'h14 +
				(cap_b[3] ? 8'h64 : 8'h00);
		end

		// charge pump
		pump_eff = i_fastlock ? pump_fast : pump_norm;
		next_st.pump_code = pump_eff;
		next_st.pump_ua = UA_W'(({7'h00, pump_eff} + 12'h001) * PUMP_STEP_UA);

		// block enables; power-down gates them but leaves the registers alone
		next_st.pd = act_pd;
		next_st.xo = act_xo;
		unique case (mode)
			SLCTM_MODE_FULL: begin
				next_st.div_en = 1'b1;
				next_st.pll_en = 1'b1;
				next_st.vco_en = 1'b1;
			end
			SLCTM_MODE_EXT_VCO: begin
				next_st.div_en = 1'b1;
				next_st.pll_en = 1'b1;
				next_st.vco_en = 1'b0;
			end
			SLCTM_MODE_DIV_ONLY: begin
				next_st.div_en = 1'b1;
				next_st.pll_en = 1'b0;
				next_st.vco_en = 1'b0;
			end
			SLCTM_MODE_TEST: begin
				next_st.div_en = 1'b1;
				next_st.pll_en = 1'b1;
				next_st.vco_en = 1'b1;
			end
		endcase
		if (act_pd) begin
			next_st.div_en = 1'b0;
			next_st.pll_en = 1'b0;
			next_st.vco_en = 1'b0;
		end

		// lock/test pin; open drain only ever pulls low
		next_st.pin = 1'b0;
		next_st.pin_oe = 1'b1;
		unique case (pin_sel)
			SLCTM_PIN_HIZ: next_st.pin_oe = 1'b0;
			SLCTM_PIN_HIGH: next_st.pin = 1'b1;
			SLCTM_PIN_LOW: next_st.pin = 1'b0;
			SLCTM_PIN_DLOCK_PP: next_st.pin = i_dig_lock;
			SLCTM_PIN_DLOCK_INV: next_st.pin = !i_dig_lock;
			SLCTM_PIN_DLOCK_OD: next_st.pin_oe = !i_dig_lock;
			SLCTM_PIN_ALOCK_OD: next_st.pin_oe = !i_ana_lock;
			SLCTM_PIN_ALOCK_PP: next_st.pin = i_ana_lock;
			SLCTM_PIN_NDIV: next_st.pin = i_ndiv_pulse;
			SLCTM_PIN_NDIV_HALF: next_st.pin = i_ndiv_half;
			SLCTM_PIN_RDIV: next_st.pin = i_rdiv_pulse;
			SLCTM_PIN_RDIV_HALF: next_st.pin = i_rdiv_half;
			SLCTM_PIN_PD_UP: next_st.pin = i_pd_up;
			SLCTM_PIN_PD_DOWN: next_st.pin = i_pd_down;
			SLCTM_PIN_RSV14: next_st.pin_oe = 1'b0;
			SLCTM_PIN_RSV15: next_st.pin_oe = 1'b0;
		endcase
		// a powered-down device leaves the pin floating
		if (act_pd) begin
			next_st.pin = 1'b0;
			next_st.pin_oe = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
			st.stg_loop <= LOOP_RST;
			st.stg_ctrl <= CTRL_RST;
			st.stg_fast <= FAST_RST;
			st.act_loop <= LOOP_RST;
			st.act_ctrl <= CTRL_RST;
			st.act_fast <= FAST_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_wb_ack = st.ack;
	assign o_wb_dat = st.rdat;
	assign o_loop_res_a_sel = st.res_a_sel;
	assign o_loop_res_a_ohm = st.res_a_ohm;
	assign o_loop_res_b_sel = st.res_b_sel;
	assign o_loop_res_b_ohm = st.res_b_ohm;
	assign o_loop_res_reserved = st.res_rsv;
	assign o_loop_cap_a_sel = st.cap_a_sel;
	assign o_loop_cap_a_pf = st.cap_a_pf;
	assign o_loop_cap_b_sel = st.cap_b_sel;
	assign o_loop_cap_b_pf = st.cap_b_pf;
	assign o_pump_current_code = st.pump_code;
	assign o_pump_current_ua = st.pump_ua;
	assign o_div_en = st.div_en;
	assign o_pll_en = st.pll_en;
	assign o_vco_en = st.vco_en;
	assign o_power_down = st.pd;
	assign o_crystal_osc_sel = st.xo;
	assign o_lock_test_pin = st.pin;
	assign o_lock_test_pin_oe = st.pin_oe;

endmodule : slctm_top
